// ---- tmr2_defs.vh ----
// Constants for the timer 2 control block: offsets, fields, reset values, timing
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH

// Register offsets
`define TMR2_OFF_CONTROL  4'h0
`define TMR2_OFF_MODE     4'h1
`define TMR2_OFF_CNT_LO   4'h2
`define TMR2_OFF_CNT_HI   4'h3
`define TMR2_OFF_CAP_LO   4'h4
`define TMR2_OFF_CAP_HI   4'h5
`define TMR2_OFF_IRQ_STAT 4'h6
`define TMR2_OFF_IRQ_MASK 4'h7

// Control register fields, and the mode register down-count enable
`define TMR2_B_OVF   7
`define TMR2_B_EXT   6
`define TMR2_B_RCLK  5
`define TMR2_B_TX_CLOCK_SELECT  4
`define TMR2_B_EXEN  3
`define TMR2_B_RUN   2
`define TMR2_B_SRC   1
`define TMR2_B_CPRL  0
`define TMR2_B_DOWN_COUNT_ENABLE  0

// Interrupt status fields
`define TMR2_S_OVF   0
`define TMR2_S_EXT   1

// Reset values
`define TMR2_RST_CONTROL 8'h00
`define TMR2_RST_MODE    8'h00
`define TMR2_RST_MASK    2'h0

// Machine cycle and baud state time lengths in system clocks
`define TMR2_DIV_6CLK    4'h6
`define TMR2_DIV_12CLK   4'hc
`define TMR2_DIV_BAUD6   4'h1
`define TMR2_DIV_BAUD12  4'h2

`endif

// ---- tmr2_edge.v ----
// Two-flop synchroniser with falling-edge detector for one pin
`timescale 1ns/1ns
`default_nettype none

module tmr2_edge (
    input  wire clk_sys,
    input  wire rst,
    input  wire pin,
    output wire level,
    output wire fall
);

    reg meta_q;
    reg sync_q;
    reg last_q;

    // First flop feeds only the second; edge is taken after it
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign fall  = last_q & ~sync_q;

endmodule

`default_nettype wire

// ---- tmr2_ctrl.v ----
// Timer 2 control, counter, capture/reload, baud pulses and register port
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "tmr2_defs.vh"

module tmr2_ctrl #(
    parameter WIDTH = 16
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       twelve_clock_mode,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       trigger_pin,
    input  wire       count_pin,
    input  wire       timer1_ovf,
    output wire       rx_baud_tick,
    output wire       tx_baud_tick,
    output wire       irq
);

    //----------------------------------------------------------------
    // Pin synchronisers
    //----------------------------------------------------------------
    wire trig_level;
    wire trig_fall;
    wire cnt_fall;

    tmr2_edge u_trig (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (trigger_pin),
        .level   (trig_level),
        .fall    (trig_fall)
    );

    tmr2_edge u_cnt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (count_pin),
        .level   (),
        .fall    (cnt_fall)
    );

    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    reg [7:0]       ctrl_q;
    reg [7:0]       mode_q;
    reg [WIDTH-1:0] cnt_q;
    reg [WIDTH-1:0] cap_q;
    reg [1:0]       stat_q;
    reg [1:0]       mask_q;
    reg [3:0]       pre_q;
    reg             baud_q;

    wire run       = ctrl_q[`TMR2_B_RUN];
    wire exen      = ctrl_q[`TMR2_B_EXEN];
    wire src_ext   = ctrl_q[`TMR2_B_SRC];
    wire rclk      = ctrl_q[`TMR2_B_RCLK];
    wire tx_clock_select      = ctrl_q[`TMR2_B_TX_CLOCK_SELECT];
    wire baud_mode = rclk | tx_clock_select;
    wire down_count_enable      = mode_q[`TMR2_B_DOWN_COUNT_ENABLE];
    wire capture   = ctrl_q[`TMR2_B_CPRL] & ~baud_mode;
    wire updown    = down_count_enable & ~baud_mode & ~capture;

    //----------------------------------------------------------------
    // Tick generation
    //----------------------------------------------------------------
    // Baud mode runs faster: one state time instead of a machine cycle
    wire [3:0] div = baud_mode ? (twelve_clock_mode ? `TMR2_DIV_BAUD12 : `TMR2_DIV_BAUD6)
                               : (twelve_clock_mode ? `TMR2_DIV_12CLK : `TMR2_DIV_6CLK);
    wire int_tick = (pre_q == div - 4'h1);

    // Prescaler free-runs so machine-cycle phase is not tied to run control
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q <= 4'h0;
        end else if (int_tick || pre_q >= div) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= pre_q + 4'h1;
        end
    end

    wire tick = run & (src_ext ? cnt_fall : int_tick);
    wire count_up = ~updown | trig_level;
    wire ovf  = tick & count_up & (&cnt_q);
    wire unf  = tick & ~count_up & (cnt_q == cap_q);
    wire wrap = ovf | unf;

    // Trigger edge is ignored without enable and in up/down mode
    wire trig_ev = exen & trig_fall & ~updown;
    wire trig_reload = trig_ev & ~capture & ~baud_mode;
    wire trig_cap    = trig_ev & capture;

    //----------------------------------------------------------------
    // Counter and capture registers
    //----------------------------------------------------------------
    wire wr_cnt_lo = reg_wr && reg_addr == `TMR2_OFF_CNT_LO;
    wire wr_cnt_hi = reg_wr && reg_addr == `TMR2_OFF_CNT_HI;
    wire wr_cap_lo = reg_wr && reg_addr == `TMR2_OFF_CAP_LO;
    wire wr_cap_hi = reg_wr && reg_addr == `TMR2_OFF_CAP_HI;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (ovf && !capture) begin
            cnt_q <= cap_q;
        end else if (unf) begin
            cnt_q <= {WIDTH{1'b1}};
        end else if (trig_reload) begin
            cnt_q <= cap_q;
        end else if (tick) begin
            cnt_q <= count_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end else if (wr_cnt_lo) begin
            cnt_q[7:0] <= reg_wdata;
        end else if (wr_cnt_hi) begin
            cnt_q[WIDTH-1:8] <= reg_wdata[WIDTH-9:0];
        end
    end

    // Capture takes the live count; software preset otherwise
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cap_q <= {WIDTH{1'b0}};
        end else if (trig_cap) begin
            cap_q <= cnt_q;
        end else if (wr_cap_lo) begin
            cap_q[7:0] <= reg_wdata;
        end else if (wr_cap_hi) begin
            cap_q[WIDTH-1:8] <= reg_wdata[WIDTH-9:0];
        end
    end

    //----------------------------------------------------------------
    // Baud pulses to the serial port
    //----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            baud_q <= 1'b0;
        end else begin
            baud_q <= ovf & baud_mode;
        end
    end

    assign rx_baud_tick = rclk ? baud_q : timer1_ovf;
    assign tx_baud_tick = tx_clock_select ? baud_q : timer1_ovf;

    //----------------------------------------------------------------
    // Control register and flags
    //----------------------------------------------------------------
    wire wr_ctrl = reg_wr && reg_addr == `TMR2_OFF_CONTROL;
    wire set_ovf = wrap & ~baud_mode;
    wire set_ext = trig_ev;
    wire tog_ext = updown & wrap;
    reg  [7:0] ctrl_d;

    // Hardware set wins over a software write in the same cycle
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata;
        end
        if (set_ovf) begin
            ctrl_d[`TMR2_B_OVF] = 1'b1;
        end
        if (set_ext) begin
            ctrl_d[`TMR2_B_EXT] = 1'b1;
        end else if (tog_ext) begin
            ctrl_d[`TMR2_B_EXT] = ~ctrl_q[`TMR2_B_EXT];
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= `TMR2_RST_CONTROL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Mode register: only down-count enable is implemented
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= `TMR2_RST_MODE;
        end else if (reg_wr && reg_addr == `TMR2_OFF_MODE) begin
            mode_q <= {7'h00, reg_wdata[`TMR2_B_DOWN_COUNT_ENABLE]};
        end
    end

    //----------------------------------------------------------------
    // Interrupt status and mask
    //----------------------------------------------------------------
    wire wr_stat = reg_wr && reg_addr == `TMR2_OFF_IRQ_STAT;
    wire ext_irq_ev = set_ext & ~down_count_enable;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stat_q <= 2'h0;
            mask_q <= `TMR2_RST_MASK;
        end else begin
            stat_q[`TMR2_S_OVF] <= set_ovf |
                (stat_q[`TMR2_S_OVF] & ~(wr_stat & reg_wdata[`TMR2_S_OVF]));
            stat_q[`TMR2_S_EXT] <= ext_irq_ev |
                (stat_q[`TMR2_S_EXT] & ~(wr_stat & reg_wdata[`TMR2_S_EXT]));
            if (reg_wr && reg_addr == `TMR2_OFF_IRQ_MASK) begin
                mask_q <= reg_wdata[1:0];
            end
        end
    end

    // Both events share one line; the handler reads which fired
    assign irq = |(stat_q & mask_q);

    //----------------------------------------------------------------
    // Read port
    //----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TMR2_OFF_CONTROL:  reg_rdata <= ctrl_q;
                `TMR2_OFF_MODE:     reg_rdata <= mode_q;
                `TMR2_OFF_CNT_LO:   reg_rdata <= cnt_q[7:0];
                `TMR2_OFF_CNT_HI:   reg_rdata <= cnt_q[WIDTH-1:8];
                `TMR2_OFF_CAP_LO:   reg_rdata <= cap_q[7:0];
                `TMR2_OFF_CAP_HI:   reg_rdata <= cap_q[WIDTH-1:8];
                `TMR2_OFF_IRQ_STAT: reg_rdata <= {6'h00, stat_q};
                `TMR2_OFF_IRQ_MASK: reg_rdata <= {6'h00, mask_q};
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// ---- tmr2_ctrl_checker.sv ----
// Port-level assertions for the timer 2 control block
`timescale 1ns/1ns
`default_nettype none
module tmr2_ctrl_checker #(
    parameter WIDTH = 16
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       twelve_clock_mode,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       trigger_pin,
    input wire logic       count_pin,
    input wire logic       timer1_ovf,
    input wire logic       rx_baud_tick,
    input wire logic       tx_baud_tick,
    input wire logic       irq
);
    // ----------------------------------------
    // Shadow of software-owned bits
    // ----------------------------------------
    logic [5:0] ctl_q;
    logic [1:0] mask_q;
    // Only writes move these, so the shadow never drifts
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_q  <= 6'h00;
            mask_q <= 2'h0;
        end else if (reg_wr && reg_addr == 4'h0) begin
            ctl_q <= reg_wdata[5:0];
        end else if (reg_wr && reg_addr == 4'h7) begin
            mask_q <= reg_wdata[1:0];
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_RX_T1: assert property (!ctl_q[5] |-> rx_baud_tick == timer1_ovf)
        else $error("receive tick not from timer 1");
    AST_TX_T1: assert property (!ctl_q[4] |-> tx_baud_tick == timer1_ovf)
        else $error("transmit tick not from timer 1");
    AST_NO_MASK: assert property (mask_q == 2'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    AST_STOP_TICK: assert property (ctl_q[4] && !$past(ctl_q[2]) && !$past(ctl_q[2], 2) |-> !tx_baud_tick)
        else $error("baud tick while stopped");
    AST_IRQ_STICKY: assert property (irq && !reg_wr |=> irq)
        else $error("interrupt dropped without a write");
    AST_EXT_OFF: assert property (mask_q == 2'h2 && !ctl_q[3] && !irq && !reg_wr |=> !irq)
        else $error("external event with enable off");
    AST_RUN_OFF: assert property (mask_q == 2'h1 && !ctl_q[2] && !irq && !reg_wr |=> !irq)
        else $error("overflow while stopped");
    AST_BAUD_OVF: assert property (mask_q == 2'h1 && ctl_q[4] && !irq && !reg_wr |=> !irq)
        else $error("overflow flag in baud mode");
    // Main scenarios reached
    cover property (reg_rd ##1 reg_rdata != 8'h00);
    cover property ($rose(irq));
    cover property (ctl_q[4] && tx_baud_tick);
endmodule
bind tmr2_ctrl tmr2_ctrl_checker #(.WIDTH(WIDTH)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .twelve_clock_mode(twelve_clock_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_pin(trigger_pin),
    .count_pin(count_pin), .timer1_ovf(timer1_ovf), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .irq(irq));
`default_nettype wire

// ---- tmr2_pins.sv ----
// Model of the trigger pin, count pin and timer 1 beside the block
`timescale 1ns/1ns
`default_nettype none
module tmr2_pins (
    input  wire logic clk_sys,
    output var  logic trigger_pin,
    output var  logic count_pin,
    output var  logic timer1_ovf
);
    // Pins idle high, timer 1 quiet
    initial begin
        trigger_pin = 1'b1;
        count_pin = 1'b1;
        timer1_ovf = 1'b0;
    end
    // Low phase outlasts the synchroniser; tail lets the edge land
    task automatic fall_trig;
        @(posedge clk_sys);
        trigger_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        trigger_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic fall_cnt;
        @(posedge clk_sys);
        count_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        count_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    // Level sets count direction in up/down mode
    task automatic set_trig(input logic v);
        @(posedge clk_sys);
        trigger_pin <= v;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t1_pulse;
        @(posedge clk_sys);
        timer1_ovf <= 1'b1;
        @(posedge clk_sys);
        timer1_ovf <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- test_tmr2_ctrl.sv ----
// Self-checking testbench for the timer 2 control block
`timescale 1ns/1ns
`default_nettype none
module test_tmr2_ctrl;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       mode12 = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    wire  [7:0] rdata;
    wire        trig, cpin, t1, rx_tick, tx_tick, irq;
    int         n_mismatch = 0;
    int         checked = 0;
    int         g;
    always #50 clk_sys = ~clk_sys;
    tmr2_ctrl dut (.clk_sys(clk_sys), .rst(rst), .twelve_clock_mode(mode12), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .trigger_pin(trig),
        .count_pin(cpin), .timer1_ovf(t1), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .irq(irq));
    tmr2_pins pins (.clk_sys(clk_sys), .trigger_pin(trig), .count_pin(cpin), .timer1_ovf(t1));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 check(rdata, exp, "register read");
    endtask
    // Bounded wait; running out ends the run as a failure
    task automatic wait_irq(input int lim, output int n);
        for (n = 0; n < lim && irq !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (n >= lim) begin
            check(8'h00, 8'h01, "interrupt wait");
            conclude();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(4'h1, 8'h00);
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h7, 8'h00);
        rd_reg(4'h9, 8'h00);
        // Machine-cycle count into overflow and auto-reload
        wr_reg(4'h4, 8'hf0);
        wr_reg(4'h5, 8'hff);
        wr_reg(4'h2, 8'hfe);
        wr_reg(4'h3, 8'hff);
        wr_reg(4'h7, 8'h01);
        wr_reg(4'h0, 8'h04);
        wait_irq(40, g);
        check(8'(g >= 6 && g <= 14), 8'h01, "overflow time");
        rd_reg(4'h0, 8'h84);
        rd_reg(4'h3, 8'hff);
        rd_reg(4'h6, 8'h01);
        wr_reg(4'h0, 8'h00);
        rd_reg(4'h0, 8'h00);
        wr_reg(4'h6, 8'h01);
        rd_reg(4'h6, 8'h00);
        // Capture on trigger, counter frozen on the quiet count pin
        wr_reg(4'h2, 8'h34);
        wr_reg(4'h3, 8'h12);
        wr_reg(4'h7, 8'h02);
        wr_reg(4'h0, 8'h0f);
        pins.fall_trig();
        wait_irq(10, g);
        rd_reg(4'h4, 8'h34);
        rd_reg(4'h5, 8'h12);
        rd_reg(4'h0, 8'h4f);
        repeat (3) pins.fall_cnt();
        rd_reg(4'h2, 8'h37);
        // Reload on trigger
        wr_reg(4'h0, 8'h0e);
        wr_reg(4'h6, 8'h03);
        pins.fall_trig();
        rd_reg(4'h2, 8'h34);
        rd_reg(4'h0, 8'h4e);
        // Trigger ignored with external enable off
        wr_reg(4'h6, 8'h03);
        wr_reg(4'h0, 8'h06);
        wr_reg(4'h2, 8'h00);
        pins.fall_trig();
        rd_reg(4'h2, 8'h00);
        rd_reg(4'h0, 8'h06);
        // Down count to underflow
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h1, 8'h01);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h5, 8'h00);
        wr_reg(4'h2, 8'h01);
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h7, 8'h03);
        pins.set_trig(1'b0);
        wr_reg(4'h0, 8'h04);
        wait_irq(40, g);
        rd_reg(4'h0, 8'hc4);
        rd_reg(4'h6, 8'h01);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h6, 8'h03);
        wr_reg(4'h1, 8'h00);
        pins.set_trig(1'b1);
        // Baud ticks in both clock modes, capture select ignored
        wr_reg(4'h4, 8'hf0);
        wr_reg(4'h5, 8'hff);
        wr_reg(4'h7, 8'h01);
        for (int m = 0; m < 2; m++) begin
            mode12 <= m[0];
            wr_reg(4'h0, 8'h34 | 8'(m));
            for (g = 0; g < 200 && tx_tick !== 1'b1; g++) @(posedge clk_sys) #1;
            @(posedge clk_sys) #1;
            for (g = 1; g < 200 && tx_tick !== 1'b1; g++) @(posedge clk_sys) #1;
            check(8'(g), 8'(16 * (m + 1)), "baud gap");
            check({7'h00, rx_tick}, 8'h01, "rx baud tick");
            pins.t1_pulse();
            rd_reg(4'h0, 8'h34 | 8'(m));
            check({7'h00, irq}, 8'h00, "baud irq");
        end
        wr_reg(4'h0, 8'h00);
        // Selects clear: both ticks follow the timer 1 pulse while it stands
        fork
            pins.t1_pulse();
            begin
                @(posedge clk_sys);
                #1;
                check({7'h00, rx_tick}, 8'h01, "rx tick from timer 1");
                check({7'h00, tx_tick}, 8'h01, "tx tick from timer 1");
            end
        join
        conclude();
    end
endmodule
`default_nettype wire
